// ===== hdl/pme_engine.sv
// Functional notes
// - channel 0 five modes, others continuous
// - continuous repeats; disable drops output at once
// - continuous: new timing from next frame
// - frame end sets per-channel flag, W1C
// - mode 0001 selects counting
// - counting emits group_frame_count frames
// - group end clears enable, sets group flag
// - mode 0011 repeats groups, both flags
// - infrared: new values at next group
// - infrared to counting finishes group, stops
// - mode 0111 plays processor-written elements
// - element bits 13:0 give frame count
// - element bit 14 picks alternate timing
// - element bit 15 carrier, else low
// - entry port takes byte, half, word writes
// - eight-byte queue with status register
// - play in order, accept during transmission
// - queue empty clears channel 0 enable
// - flush bit discards all queued bytes
// - mode 1111 takes elements from DMA
// - DMA enable sets channel 0 enable
// - queue drained sets stop flag, W1C
// - output high below compare, low after
// - count below trigger level raises event
module pme_engine
    import pme_pkg::*;
#(
    parameter int QUEUE_DEPTH = 8
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    input  wire logic [12:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_dma_enable,
    input  wire logic        i_dma_valid,
    input  wire logic [15:0] i_dma_data,
    output logic             o_dma_ready,
    output logic      [5:0]  o_pwm,
    output logic             o_irq
);

    localparam int PW = $clog2(QUEUE_DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] Q_FULL = CW'(QUEUE_DEPTH);
    localparam logic [CW-1:0] Q_TWO  = CW'(2);

    // the status count field is four bits and a word write pushes four
    if (QUEUE_DEPTH < 4 || QUEUE_DEPTH > 8 ||
        (1 << PW) != QUEUE_DEPTH) begin : g_bad_depth
        $error("QUEUE_DEPTH must be 4 or 8");
    end

    // bus slave: one wait cycle, then the answer
    logic        ack;
    logic [10:0] idx;
    logic        wr_go;
    logic        wb0;
    logic [7:0]  wd8;
    logic [31:0] rd_val;

    assign idx               = i_avs_address[12:2];
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
    assign wr_go             = i_avs_write & ack;
    assign wb0               = wr_go & i_avs_byteenable[0];
    assign wd8               = i_avs_writedata[7:0];

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ack <= 1'b0;
        end else if (i_clk_en) begin
            ack <= (i_avs_read | i_avs_write) & ~ack;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_clk_en && i_avs_read && !ack) begin
            o_avs_readdata <= rd_val;
        end
    end

    // software registers
    logic [5:1]  en_hi;
    logic        en0;
    logic [7:0]  mode;
    logic [15:0] pnum;
    logic [7:0]  mask0;
    logic [7:0]  flag0;
    logic [7:0]  mask1;
    logic [7:0]  flag1;
    logic [15:0] alt_cmp;
    logic [15:0] alt_max;
    logic [7:0]  trig;
    logic [15:0] cmp_r [PME_NUM_CH];
    logic [15:0] max_r [PME_NUM_CH];

    logic [3:0]  mode_f;
    logic        q_mode;
    logic        m_count;
    logic        m_ir;
    logic        m_dma;
    logic        cont0;

    assign mode_f  = mode[3:0];
    assign q_mode  = pme_is_queue(mode_f);
    assign m_count = (mode_f == PME_MODE_COUNT);
    assign m_ir    = (mode_f == PME_MODE_IR);
    assign m_dma   = (mode_f == PME_MODE_DMA);
    assign cont0   = !(m_count || m_ir || q_mode);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            en_hi   <= 5'h00;
            mode    <= PME_RST_REG8;
            pnum    <= PME_RST_REG16;
            mask0   <= PME_RST_REG8;
            mask1   <= PME_RST_REG8;
            alt_cmp <= PME_RST_ALT_CMP;
            alt_max <= PME_RST_REG16;
            trig    <= PME_RST_REG8;
        end else if (i_clk_en && wb0) begin
            case (idx)
                PME_IDX_EN_HI:                 en_hi         <= wd8[5:1];
                PME_IDX_MODE:                  mode          <= wd8;
                PME_IDX_PNUM_LO:               pnum[7:0]     <= wd8;
                PME_IDX_PNUM_HI:               pnum[15:8]    <= wd8;
                PME_IDX_MASK0:                 mask0         <= wd8;
                PME_IDX_MASK1:                 mask1         <= wd8;
                PME_IDX_ALT_CMP:               alt_cmp[7:0]  <= wd8;
                PME_IDX_ALT_CMP + 11'h001:     alt_cmp[15:8] <= wd8;
                PME_IDX_ALT_MAX:               alt_max[7:0]  <= wd8;
                PME_IDX_ALT_MAX + 11'h001:     alt_max[15:8] <= wd8;
                PME_IDX_TRIG:                  trig          <= wd8;
                default: ;
            endcase
        end
    end

    for (genvar c = 0; c < PME_NUM_CH; c++) begin : g_treg
        localparam logic [10:0] B =
            PME_IDX_CMP_BASE + PME_IDX_CH_STRIDE * 11'(c);
        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                cmp_r[c] <= PME_RST_REG16;
                max_r[c] <= PME_RST_REG16;
            end else if (i_clk_en && wb0) begin
                if (idx == B) cmp_r[c][7:0] <= wd8;
                if (idx == B + 11'h001) cmp_r[c][15:8] <= wd8;
                if (idx == B + PME_IDX_MAX_OFS) max_r[c][7:0] <= wd8;
                if (idx == B + PME_IDX_MAX_OFS + 11'h001) begin
                    max_r[c][15:8] <= wd8;
                end
            end
        end
    end

    // element queue
    logic [7:0]    q_mem [QUEUE_DEPTH];
    logic [PW-1:0] q_wr;
    logic [PW-1:0] q_rd;
    logic [PW-1:0] q_rd1;
    logic [CW-1:0] q_cnt;
    logic [2:0]    push_n;
    logic [31:0]   push_d;
    logic          push_ok;
    logic [2:0]    acc_n;
    logic          pop;
    logic          flush;
    logic [15:0]   head;
    logic          have_elem;
    logic          dma_push;

    assign q_rd1     = q_rd + 1'b1;
    assign head      = {q_mem[q_rd1], q_mem[q_rd]};
    assign have_elem = (q_cnt >= Q_TWO);
    assign flush     = wb0 && (idx == PME_IDX_FLUSH) && wd8[0];
    assign o_dma_ready = m_dma && (q_cnt <= Q_FULL - Q_TWO);
    assign dma_push  = o_dma_ready && i_dma_valid;

    always_comb begin
        push_n = 3'd0;
        push_d = i_avs_writedata;
        if (m_dma) begin
            push_n = dma_push ? 3'd2 : 3'd0;
            push_d = {16'h0000, i_dma_data};
        end else if (wr_go && idx == PME_IDX_ENTRY) begin
            // lanes fill in order: byte, half word or word
            if (i_avs_byteenable[0]) begin
                push_n = !i_avs_byteenable[1] ? 3'd1 :
                         (&i_avs_byteenable[3:2]) ? 3'd4 : 3'd2;
            end
        end else if (wr_go && idx > PME_IDX_ENTRY &&
                     idx <= PME_IDX_ENTRY_END) begin
            push_n = i_avs_byteenable[0] ? 3'd1 : 3'd0;
        end
    end

    // a push that does not fit is dropped whole, so bytes never split, except a word write to a full queue at QUEUE_DEPTH 4, which is taken
    assign push_ok = (q_cnt + CW'(push_n)) <= Q_FULL;
    assign acc_n   = push_ok ? push_n : 3'd0;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            q_wr  <= '0;
            q_rd  <= '0;
            q_cnt <= '0;
        end else if (i_clk_en) begin
            if (flush) begin
                q_wr  <= '0;
                q_rd  <= '0;
                q_cnt <= '0;
            end else begin
                q_wr  <= q_wr + PW'(acc_n);
                q_rd  <= q_rd + (pop ? PW'(2) : PW'(0));
                q_cnt <= q_cnt + CW'(acc_n) - (pop ? Q_TWO : CW'(0));
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_clk_en && !flush) begin
            for (int k = 0; k < 4; k++) begin
                if (3'(k) < acc_n) begin
                    q_mem[q_wr + PW'(k)] <= push_d[8*k +: 8];
                end
            end
        end
    end

    // channel 0 group sequencer
    pme_state_t    st;
    logic [15:0]   g_len;
    logic [15:0]   g_cnt;
    logic [15:0]   nx_len;
    logic [15:0]   nx_cmp;
    logic [15:0]   nx_max;
    logic          nx_car;
    logic          start_ok;
    logic          g_end;
    logic          gstart;
    logic          stop_group;
    logic          stop_empty;
    logic          dma_en_d;
    logic          dma_rise;
    logic [5:0]    fend;
    logic [5:0]    ch_run;
    logic [5:0]    ch_load;
    logic [5:0]    ch_reload;
    logic [15:0]   src_cmp [PME_NUM_CH];
    logic [15:0]   src_max [PME_NUM_CH];
    logic [5:0]    src_car;

    always_comb begin
        nx_len = pnum;
        nx_cmp = cmp_r[0];
        nx_max = max_r[0];
        nx_car = 1'b1;
        if (q_mode) begin
            nx_len = {2'b00, head[PME_ELEM_LEN_W-1:0]};
            nx_car = head[PME_ELEM_CAR_BIT];
            if (head[PME_ELEM_ALT_BIT]) begin
                nx_cmp = alt_cmp;
                nx_max = alt_max;
            end
        end
    end

    assign start_ok   = !q_mode || have_elem;
    assign g_end      = (st == PME_ST_RUN) && fend[0] && !cont0 &&
                        ({1'b0, g_cnt} + 17'h00001 >= {1'b0, g_len});
    assign stop_group = g_end && m_count;
    assign stop_empty = (g_end && q_mode && !have_elem) ||
                        ((st == PME_ST_IDLE) && en0 && q_mode &&
                         !have_elem && !(m_dma && i_dma_enable));
    assign gstart     = en0 && start_ok &&
                        ((st == PME_ST_IDLE) || (g_end && !m_count));
    assign pop        = gstart && q_mode;
    assign dma_rise   = i_dma_enable && !dma_en_d;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st       <= PME_ST_IDLE;
            en0      <= 1'b0;
            g_len    <= PME_RST_REG16;
            g_cnt    <= PME_RST_REG16;
            dma_en_d <= 1'b0;
        end else if (i_clk_en) begin
            dma_en_d <= i_dma_enable;
            if (m_dma && dma_rise) begin
                en0 <= 1'b1;
            end else if (wb0 && idx == PME_IDX_EN0) begin
                en0 <= wd8[0];
            end else if (stop_group || stop_empty) begin
                en0 <= 1'b0;
            end
            if (gstart) begin
                g_len <= nx_len;
                g_cnt <= 16'h0000;
            end else if (fend[0]) begin
                g_cnt <= g_cnt + 16'h0001;
            end
            case (st)
                PME_ST_IDLE: if (gstart) st <= PME_ST_RUN;
                PME_ST_RUN: begin
                    // disable stops mid-frame, ending the group early
                    if (!en0 || stop_group || stop_empty) begin
                        st <= PME_ST_IDLE;
                    end
                end
                default: st <= PME_ST_IDLE;
            endcase
        end
    end

    assign ch_run[0]    = (st == PME_ST_RUN) && en0;
    assign ch_load[0]   = gstart;
    assign ch_reload[0] = cont0;
    assign src_cmp[0]   = nx_cmp;
    assign src_max[0]   = nx_max;
    assign src_car[0]   = nx_car;

    logic [5:1] en_hi_d;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            en_hi_d <= 5'h00;
        end else if (i_clk_en) begin
            en_hi_d <= en_hi;
        end
    end

    for (genvar c = 1; c < PME_NUM_CH; c++) begin : g_src
        assign ch_run[c]    = en_hi[c] && en_hi_d[c];
        assign ch_load[c]   = en_hi[c] && !en_hi_d[c];
        assign ch_reload[c] = 1'b1;
        assign src_cmp[c]   = cmp_r[c];
        assign src_max[c]   = max_r[c];
        assign src_car[c]   = 1'b1;
    end

    // frame generators
    for (genvar c = 0; c < PME_NUM_CH; c++) begin : g_ch
        logic [15:0] cnt;
        logic [15:0] lcmp;
        logic [15:0] lmax;
        logic        lcar;

        // a zero cycle length gives one-cycle frames rather than a hang
        assign fend[c] = ch_run[c] &&
                         ({1'b0, cnt} + 17'h00001 >= {1'b0, lmax});

        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                cnt  <= PME_RST_REG16;
                lcmp <= PME_RST_REG16;
                lmax <= PME_RST_REG16;
                lcar <= 1'b0;
            end else if (i_clk_en) begin
                if (ch_load[c]) begin
                    cnt  <= 16'h0000;
                    lcmp <= src_cmp[c];
                    lmax <= src_max[c];
                    lcar <= src_car[c];
                end else if (!ch_run[c]) begin
                    cnt <= 16'h0000;
                end else if (fend[c]) begin
                    cnt <= 16'h0000;
                    if (ch_reload[c]) begin
                        lcmp <= src_cmp[c];
                        lmax <= src_max[c];
                        lcar <= src_car[c];
                    end
                end else begin
                    cnt <= cnt + 16'h0001;
                end
            end
        end

        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                o_pwm[c] <= 1'b0;
            end else if (i_clk_en) begin
                o_pwm[c] <= ch_run[c] && lcar && (cnt < lcmp);
            end
        end
    end

    // flags: hardware set wins over a same-cycle write-one clear
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic       q_low;
    logic       q_low_d;

    assign q_low = {{(8 - CW){1'b0}}, q_cnt} <
                   {{(8 - PME_TRIG_W){1'b0}}, trig[PME_TRIG_W-1:0]};

    always_comb begin
        set0 = 8'h00;
        set1 = 8'h00;
        set0[PME_F0_FRAME_LSB +: PME_NUM_CH] = fend;
        set0[PME_F0_GROUP] = g_end && (m_count || m_ir);
        set1[PME_F1_STOP]  = stop_empty;
        set1[PME_F1_LEVEL] = q_mode && q_low && !q_low_d;
    end

    assign clr0 = (wb0 && idx == PME_IDX_FLAG0) ? wd8 : 8'h00;
    assign clr1 = (wb0 && idx == PME_IDX_FLAG1) ? wd8 : 8'h00;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flag0   <= PME_RST_REG8;
            flag1   <= PME_RST_REG8;
            q_low_d <= 1'b0;
            o_irq   <= 1'b0;
        end else if (i_clk_en) begin
            flag0   <= (flag0 & ~clr0) | set0;
            flag1   <= (flag1 & ~clr1) | set1;
            q_low_d <= q_low;
            o_irq   <= |(flag0 & mask0) || |(flag1 & mask1);
        end
    end

    // read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx)
            PME_IDX_EN_HI:             rd_val[5:1] = en_hi;
            PME_IDX_EN0:               rd_val[0]   = en0;
            PME_IDX_MODE:              rd_val[7:0] = mode;
            PME_IDX_PNUM_LO:           rd_val[7:0] = pnum[7:0];
            PME_IDX_PNUM_HI:           rd_val[7:0] = pnum[15:8];
            PME_IDX_MASK0:             rd_val[7:0] = mask0;
            PME_IDX_FLAG0:             rd_val[7:0] = flag0;
            PME_IDX_MASK1:             rd_val[7:0] = mask1;
            PME_IDX_FLAG1:             rd_val[7:0] = flag1;
            PME_IDX_ALT_CMP:           rd_val[7:0] = alt_cmp[7:0];
            PME_IDX_ALT_CMP + 11'h001: rd_val[7:0] = alt_cmp[15:8];
            PME_IDX_ALT_MAX:           rd_val[7:0] = alt_max[7:0];
            PME_IDX_ALT_MAX + 11'h001: rd_val[7:0] = alt_max[15:8];
            PME_IDX_TRIG:              rd_val[7:0] = trig;
            PME_IDX_STATUS: begin
                rd_val[CW-1:0]       = q_cnt;
                rd_val[PME_ST_EMPTY] = (q_cnt == '0);
                rd_val[PME_ST_FULL]  = (q_cnt == Q_FULL);
            end
            default: begin
                for (int c = 0; c < PME_NUM_CH; c++) begin
                    if (idx == PME_IDX_CMP_BASE +
                        PME_IDX_CH_STRIDE * 11'(c)) begin
                        rd_val[7:0] = cmp_r[c][7:0];
                    end
                    if (idx == PME_IDX_CMP_BASE + 11'h001 +
                        PME_IDX_CH_STRIDE * 11'(c)) begin
                        rd_val[7:0] = cmp_r[c][15:8];
                    end
                    if (idx == PME_IDX_CMP_BASE + PME_IDX_MAX_OFS +
                        PME_IDX_CH_STRIDE * 11'(c)) begin
                        rd_val[7:0] = max_r[c][7:0];
                    end
                    if (idx == PME_IDX_CMP_BASE + PME_IDX_MAX_OFS +
                        11'h001 + PME_IDX_CH_STRIDE * 11'(c)) begin
                        rd_val[7:0] = max_r[c][15:8];
                    end
                end
            end
        endcase
    end

endmodule

// ===== hdl/pme_pkg.sv
package pme_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [10:0] PME_IDX_EN_HI     = 11'h780;
    localparam logic [10:0] PME_IDX_EN0       = 11'h781;
    localparam logic [10:0] PME_IDX_MODE      = 11'h783;
    localparam logic [10:0] PME_IDX_CMP_BASE  = 11'h794;
    localparam logic [10:0] PME_IDX_CH_STRIDE = 11'h004;
    localparam logic [10:0] PME_IDX_MAX_OFS   = 11'h002;
    localparam logic [10:0] PME_IDX_PNUM_LO   = 11'h7AC;
    localparam logic [10:0] PME_IDX_PNUM_HI   = 11'h7AD;
    localparam logic [10:0] PME_IDX_MASK0     = 11'h7B0;
    localparam logic [10:0] PME_IDX_FLAG0     = 11'h7B1;
    localparam logic [10:0] PME_IDX_MASK1     = 11'h7B2;
    localparam logic [10:0] PME_IDX_FLAG1     = 11'h7B3;
    localparam logic [10:0] PME_IDX_ALT_CMP   = 11'h7C4;
    localparam logic [10:0] PME_IDX_ALT_MAX   = 11'h7C6;
    localparam logic [10:0] PME_IDX_ENTRY     = 11'h7C8;
    localparam logic [10:0] PME_IDX_ENTRY_END = 11'h7CB;
    localparam logic [10:0] PME_IDX_TRIG      = 11'h7CC;
    localparam logic [10:0] PME_IDX_STATUS    = 11'h7CD;
    localparam logic [10:0] PME_IDX_FLUSH     = 11'h7CE;

    localparam int PME_NUM_CH = 6;

    // channel 0 mode field values
    localparam logic [3:0] PME_MODE_COUNT = 4'h1;
    localparam logic [3:0] PME_MODE_IR    = 4'h3;
    localparam logic [3:0] PME_MODE_QUEUE = 4'h7;
    localparam logic [3:0] PME_MODE_DMA   = 4'hF;

    // waveform element layout
    localparam int PME_ELEM_LEN_W   = 14;
    localparam int PME_ELEM_ALT_BIT = 14;
    localparam int PME_ELEM_CAR_BIT = 15;

    // flag and status bit positions
    localparam int PME_F0_GROUP     = 0;
    localparam int PME_F0_FRAME_LSB = 2;
    localparam int PME_F1_STOP      = 0;
    localparam int PME_F1_LEVEL     = 1;
    localparam int PME_ST_EMPTY     = 4;
    localparam int PME_ST_FULL      = 5;
    localparam int PME_TRIG_W       = 4;

    // reset values
    localparam logic [7:0]  PME_RST_REG8    = 8'h00;
    localparam logic [15:0] PME_RST_REG16   = 16'h0000;
    localparam logic [15:0] PME_RST_ALT_CMP = 16'h5555;

    typedef enum logic [0:0] {PME_ST_IDLE, PME_ST_RUN} pme_state_t;

    function automatic logic pme_is_queue(input logic [3:0] m);
        return (m == PME_MODE_QUEUE) || (m == PME_MODE_DMA);
    endfunction

endpackage

// ===== sim/pme_engine_chk.sv
module pme_engine_chk
    import pme_pkg::*;
#(
    parameter int QUEUE_DEPTH = 8
) (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic [12:0] i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [5:0]  o_pwm
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    logic        req;
    logic        ack;
    logic [10:0] idx;
    logic [3:0]  cnt;
    assign req = i_avs_read | i_avs_write;
    assign ack = req & ~o_avs_waitrequest;
    assign idx = i_avs_address[12:2];
    assign cnt = o_avs_readdata[3:0];
    property p_wait_first; $rose(req) |-> o_avs_waitrequest; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait");
    property p_wait_one; req && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait too long");
    property p_idle; !req |-> !o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("wait while idle");
    // readdata must not drift between reads
    property p_rd_hold; !i_avs_read |=> $stable(o_avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
    property p_unmap;
        i_avs_read && ack && idx == 11'h7C2 |-> o_avs_readdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_status;
        i_avs_read && ack && idx == PME_IDX_STATUS |->
            o_avs_readdata[4] == (cnt == 4'h0) && cnt <= QUEUE_DEPTH &&
            o_avs_readdata[5] == (cnt == QUEUE_DEPTH);
    endproperty
    a_status: assert property (p_status) else $error("status bad");
    property p_dis0; i_avs_write && ack && idx == PME_IDX_EN0 &&
        !i_avs_writedata[0] |=> ##[0:1] !o_pwm[0]; endproperty
    a_dis0: assert property (p_dis0) else $error("ch0 not low");
    property p_dis_hi; i_avs_write && ack && idx == PME_IDX_EN_HI &&
        i_avs_writedata[5:1] == 5'h0 |=> ##[0:1] o_pwm[5:1] == 5'h0;
    endproperty
    a_dis_hi: assert property (p_dis_hi) else $error("ch1-5 on");
endmodule

// ===== sim/pme_load.sv
module pme_load (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output int        o_pulses,
    output int        o_high
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev;
    // passive emitter: only tallies pulses and lit cycles
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prev <= 1'b0;
            o_pulses <= 0;
            o_high <= 0;
        end else begin
            prev <= i_pin;
            o_pulses <= o_pulses + int'(i_pin & ~prev);
            o_high <= o_high + int'(i_pin);
        end
    end
endmodule

// ===== sim/pme_engine_bench.sv
module pme_engine_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pme_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_clk_en = 1'b1;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic        i_dma_enable = 1'b0;
    logic        i_dma_valid = 1'b0;
    logic [12:0] i_avs_address = 13'h0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'h0;
    logic [15:0] i_dma_data = 16'h0;
    logic [31:0] o_avs_readdata;
    logic [31:0] rdata;
    logic        o_avs_waitrequest;
    logic        o_dma_ready;
    logic        o_irq;
    logic [5:0]  o_pwm;
    int          err_total = 0;
    int          compares = 0;
    int          pul, hig, p0, h0, n;
    pme_engine #(.QUEUE_DEPTH(8)) uut (.*);
    pme_load ld (.i_clock(i_clock), .i_rst(i_rst), .i_pin(o_pwm[0]),
                 .o_pulses(pul), .o_high(hig));
    always #12.5 i_clock = ~i_clock;
    task bus(input logic w, input logic [10:0] a, input logic [31:0] d,
             input logic [3:0] be);
        i_avs_write <= w;
        i_avs_read <= ~w;
        i_avs_address <= {a, 2'b00};
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) err_total++;
        rdata = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        // idle edge keeps back-to-back strobes apart
        @(posedge i_clock);
    endtask
    task wr(input logic [10:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task rdchk(input string nm, input logic [10:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'h1);
        chk(nm, e, rdata);
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rdchk("status", PME_IDX_STATUS, 32'h10);
        rdchk("alt cmp", PME_IDX_ALT_CMP, 32'h55);
        rdchk("unmapped", 11'h7C2, 32'h0);
        $display("reset test done");
        wr(PME_IDX_CMP_BASE, 32'h2);
        wr(PME_IDX_CMP_BASE + PME_IDX_MAX_OFS, 32'h5);
        wr(PME_IDX_PNUM_LO, 32'h3);
        wr(PME_IDX_MODE, {28'h0, PME_MODE_COUNT});
        wr(PME_IDX_MASK0, 32'h5);
        wr(PME_IDX_EN0, 32'h1);
        repeat (40) @(posedge i_clock);
        chk("pulses", 32'd3, pul);
        chk("lit", 32'd6, hig);
        rdchk("en0", PME_IDX_EN0, 32'h0);
        rdchk("flags0", PME_IDX_FLAG0, 32'h5);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(PME_IDX_FLAG0, 32'h5);
        @(posedge i_clock);
        chk("irq", 32'h0, {31'h0, o_irq});
        $display("count test done");
        p0 = pul;
        wr(PME_IDX_PNUM_LO, 32'h2);
        wr(PME_IDX_MODE, {28'h0, PME_MODE_IR});
        wr(PME_IDX_EN0, 32'h1);
        repeat (14) @(posedge i_clock);
        wr(PME_IDX_MODE, {28'h0, PME_MODE_COUNT});
        repeat (30) @(posedge i_clock);
        chk("ir pulses", p0 + 4, pul);
        rdchk("ir flags", PME_IDX_FLAG0, 32'h5);
        wr(PME_IDX_MODE, {28'h0, PME_MODE_IR});
        wr(PME_IDX_EN0, 32'h1);
        repeat (7) @(posedge i_clock);
        wr(PME_IDX_EN0, 32'h0);
        repeat (2) @(posedge i_clock);
        chk("ir off", 32'h0, {31'h0, o_pwm[0]});
        $display("ir test done");
        wr(PME_IDX_FLAG0, 32'hFF);
        wr(PME_IDX_MODE, {28'h0, PME_MODE_QUEUE});
        wr(PME_IDX_ALT_CMP, 32'h1);
        wr(PME_IDX_ALT_CMP + 11'h1, 32'h0);
        wr(PME_IDX_ALT_MAX, 32'h3);
        wr(PME_IDX_FLUSH, 32'h1);
        wr(PME_IDX_MASK1, 32'h1);
        bus(1'b1, PME_IDX_ENTRY, 32'hC003_8002, 4'hF);
        bus(1'b1, PME_IDX_ENTRY, 32'h0002, 4'h3);
        wr(PME_IDX_ENTRY, 32'h01);
        wr(PME_IDX_ENTRY + 11'h1, 32'h80);
        rdchk("full", PME_IDX_STATUS, 32'h28);
        wr(PME_IDX_ENTRY, 32'h07);
        rdchk("overflow", PME_IDX_STATUS, 32'h28);
        p0 = pul;
        h0 = hig;
        wr(PME_IDX_EN0, 32'h1);
        bus(1'b1, PME_IDX_ENTRY, 32'h8001, 4'h3);
        repeat (70) @(posedge i_clock);
        chk("q pulses", p0 + 7, pul);
        chk("q lit", h0 + 11, hig);
        rdchk("q en0", PME_IDX_EN0, 32'h0);
        rdchk("q flags1", PME_IDX_FLAG1, 32'h1);
        chk("q irq", 32'h1, {31'h0, o_irq});
        wr(PME_IDX_FLAG1, 32'h1);
        bus(1'b1, PME_IDX_ENTRY, 32'h8001_8001, 4'hF);
        wr(PME_IDX_FLUSH, 32'h1);
        rdchk("flush", PME_IDX_STATUS, 32'h10);
        $display("queue test done");
        wr(PME_IDX_MODE, {28'h0, PME_MODE_DMA});
        p0 = pul;
        i_dma_data <= 16'h8002;
        i_dma_valid <= 1'b1;
        @(posedge i_clock);
        chk("dma ready", 32'h1, {31'h0, o_dma_ready});
        i_dma_valid <= 1'b0;
        i_dma_enable <= 1'b1;
        repeat (3) @(posedge i_clock);
        rdchk("dma en0", PME_IDX_EN0, 32'h1);
        i_dma_enable <= 1'b0;
        repeat (30) @(posedge i_clock);
        chk("dma pulses", p0 + 2, pul);
        rdchk("dma en0", PME_IDX_EN0, 32'h0);
        rdchk("dma flags1", PME_IDX_FLAG1, 32'h1);
        $display("dma test done");
        wr(PME_IDX_FLAG0, 32'hFF);
        wr(PME_IDX_CMP_BASE + PME_IDX_CH_STRIDE, 32'h1);
        wr(PME_IDX_CMP_BASE + PME_IDX_CH_STRIDE + PME_IDX_MAX_OFS, 32'h4);
        wr(PME_IDX_EN_HI, 32'h02);
        repeat (20) @(posedge i_clock);
        rdchk("ch1 flag", PME_IDX_FLAG0, 32'h08);
        wr(PME_IDX_EN_HI, 32'h0);
        repeat (2) @(posedge i_clock);
        chk("ch1 off", 32'h0, {31'h0, o_pwm[1]});
        $display("continuous test done");
        give_verdict;
    end
endmodule
bind pme_engine pme_engine_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk (.*);
